// >>> dv/line_partner.sv
`timescale 1ns/1ps
// ============================================================
// other units on the shared lines; our reset leaves their levels standing
module line_partner (
   input wire logic clk_sys_i,
   input wire logic [2:0] unit_a_i,
   input wire logic [2:0] unit_b_i,
   output logic [2:0] line_in_o
);
   logic [2:0] next_line;
   always_comb begin
      next_line = unit_a_i | unit_b_i;
   end
   always_ff @(posedge clk_sys_i) begin
      line_in_o <= next_line;
   end
endmodule : line_partner

// >>> dv/shared_signal_bus_assign_assertions.sv
`timescale 1ns/1ps
// ============================================================
// port checks for the shared line block
module shared_signal_bus_assign_assertions (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [2:0] line_in_i,
   input wire logic [2:0] line_drive_o,
   input wire logic end_aux_output_one_o,
   input wire logic end_aux_output_two_o,
   input wire logic [132:0] func_level_o,
   input wire logic [132:0] func_change_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   logic [1:0] up;
   logic [1:0] next_up;
   // edges since release: $past is trusted only once up reaches 3
   always_comb begin
      next_up = (up == 2'h3) ? up : up + 2'h1;
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         up <= 2'h0;
      end else begin
         up <= next_up;
      end
   end
   sequence s_ar_taken;
      s_axi_arvalid_i && s_axi_arready_o;
   endsequence
   sequence s_w_taken;
      s_axi_wvalid_i && s_axi_wready_o;
   endsequence
   a_read_answer: assert property (s_ar_taken |->
      ##[1:4] s_axi_rvalid_o) else $error("read not answered");
   a_write_answer: assert property (s_w_taken |->
      ##[1:4] s_axi_bvalid_o) else $error("write not answered");
   a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write answer dropped");
   a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read answer dropped");
   a_aux_one: assert property (up == 2'h3 |-> end_aux_output_one_o ==
      $past(line_in_i[0] | line_drive_o[0])) else $error("aux one wrong");
   a_aux_two: assert property (up == 2'h3 |-> end_aux_output_two_o ==
      $past(line_in_i[1] | line_drive_o[1])) else $error("aux two wrong");
   a_pulse_cause: assert property (up == 2'h3 && func_change_o != '0
      |-> $past(line_in_i|line_drive_o) != $past(line_in_i|line_drive_o, 2))
      else $error("pulse without line change");
   a_code_none: assert property (!func_level_o[0]
      && !func_change_o[0]) else $error("code zero acted");
   a_drive_start: assert property (up < 2'h2 |-> line_drive_o == 3'h0)
      else $error("drive after power-up");
endmodule : shared_signal_bus_assign_assertions

bind shared_signal_bus_assign shared_signal_bus_assign_assertions
   shared_signal_bus_assign_assertions_inst (.clk_sys_i, .rst_n_i,
   .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i,
   .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
   .s_axi_rready_i, .s_axi_rdata_o, .line_in_i, .line_drive_o,
   .end_aux_output_one_o, .end_aux_output_two_o, .func_level_o,
   .func_change_o);

// >>> dv/shared_signal_bus_assign_bench.sv
`timescale 1ns/1ps
module shared_signal_bus_assign_bench;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, awready, wready;
   logic arvalid = 1'b0, rready = 1'b0, arready, bvalid, rvalid;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, in_a, out_a;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [1:0] bresp, rresp, iface_ev = 2'h0, bank;
   logic [2:0] line_in, line_drive, unit_a = 3'h0, unit_b = 3'h0;
   logic aux1, aux2, irq, present = 1'b0, multi = 1'b0;
   logic [15:0] fault = 16'h0000;
   logic [150:0] src = '0;
   logic [132:0] flevel, fchange;
   int n_mismatch = 0, check_count = 0, cyc = 0;
   always #50 clk_sys_i = ~clk_sys_i;
   line_partner line_partner_inst (.clk_sys_i(clk_sys_i), .unit_a_i(unit_a),
      .unit_b_i(unit_b), .line_in_o(line_in));
   shared_signal_bus_assign #(.FOUR_CHANNEL(1'b1))
      shared_signal_bus_assign_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .line_in_i(line_in), .line_drive_o(line_drive),
      .end_aux_output_one_o(aux1), .end_aux_output_two_o(aux2),
      .fault_status_i(fault), .src_i(src), .iface_event_i(iface_ev),
      .iface_present_i(present), .multidrop_i(multi),
      .func_level_o(flevel), .func_change_o(fchange), .bank_o(bank),
      .irq_o(irq));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // settle point off the clock edge, after that edge's updates
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
   endtask : tick
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      logic ah, wh, bh;
      logic [1:0] r;
      bh = 1'b0;
      @(posedge clk_sys_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      repeat (40) begin
         if (!bh) begin
            @(negedge clk_sys_i);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid && bready;
            r = bresp;
            @(posedge clk_sys_i);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bh) bready <= 1'b0;
         end
      end
      chk({31'h0, bh}, 32'h0000_0001);
      chk({30'h0, r}, {30'h0, er});
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                         input logic [1:0] er);
      logic ah, rh;
      logic [1:0] r;
      logic [31:0] d;
      rh = 1'b0;
      @(posedge clk_sys_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      repeat (40) begin
         if (!rh) begin
            @(negedge clk_sys_i);
            ah = arvalid && arready;
            rh = rvalid && rready;
            r = rresp;
            d = rdata;
            @(posedge clk_sys_i);
            if (ah) arvalid <= 1'b0;
            if (rh) rready <= 1'b0;
         end
      end
      chk({31'h0, rh}, 32'h0000_0001);
      chk(d, ed);
      chk({30'h0, r}, {30'h0, er});
   endtask : axi_rd
   initial begin
      logic [1:0] ok, err;
      ok = shared_bus_pkg::RESP_OKAY;
      err = shared_bus_pkg::RESP_SLVERR;
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      // ============================================================
      // defaults, ranges, refused writes
      for (int i = 0; i < 3; i++) begin
         in_a = shared_bus_pkg::ADDR_IN_SEL0 + 8'(4 * i);
         out_a = shared_bus_pkg::ADDR_OUT_SEL0 + 8'(4 * i);
         axi_rd(in_a, 32'h0000_0000, ok);
         axi_rd(out_a, 32'h0000_0000, ok);
         axi_wr(in_a, shared_bus_pkg::IN_MAX_FOUR, ok);
         axi_wr(in_a, shared_bus_pkg::IN_MAX_FOUR + 8'h01, err);
         axi_rd(in_a, shared_bus_pkg::IN_MAX_FOUR, ok);
         axi_wr(out_a, shared_bus_pkg::OUT_MAX_FOUR, ok);
         axi_wr(out_a, shared_bus_pkg::OUT_MAX_FOUR + 8'h01, err);
         axi_rd(out_a, shared_bus_pkg::OUT_MAX_FOUR, ok);
         axi_wr(in_a, 32'h0000_0000, ok);
         axi_wr(out_a, 32'h0000_0000, ok);
      end
      axi_rd(8'h30, 32'h0000_0000, err);
      axi_rd(shared_bus_pkg::ADDR_IRQ_STAT, 32'h0000_0008, ok);
      axi_wr(shared_bus_pkg::ADDR_CTRL, 32'h0000_0001, ok);
      axi_wr(shared_bus_pkg::ADDR_IN_SEL0, 32'h0000_0005, err);
      axi_rd(shared_bus_pkg::ADDR_IN_SEL0, 32'h0000_0000, ok);
      axi_wr(shared_bus_pkg::ADDR_CTRL, 32'h0000_0000, ok);
      $display("test registers done");
      // ============================================================
      // assignments go live only at soft reset
      src[5] <= 1'b1;
      axi_wr(shared_bus_pkg::ADDR_OUT_SEL0, 32'h0000_0005, ok);
      axi_wr(shared_bus_pkg::ADDR_OUT_SEL0 + 8'h04, 32'h0000_0001, ok);
      axi_wr(shared_bus_pkg::ADDR_IN_SEL0, 32'h0000_0007, ok);
      axi_wr(shared_bus_pkg::ADDR_IN_SEL0 + 8'h08, 32'h0000_0001, ok);
      tick(2);
      chk({29'h0, line_drive}, 32'h0000_0000);
      axi_wr(shared_bus_pkg::ADDR_CTRL, 32'h0000_0002, ok);
      tick(3);
      chk({29'h0, line_drive}, 32'h0000_0001);
      chk({31'h0, aux1}, 32'h0000_0001);
      chk({31'h0, flevel[7]}, 32'h0000_0001);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_sys_i) fault <= 16'h0001 << (k * 5);
         tick(3);
         chk({31'h0, aux2}, {31'h0, k < 3});
      end
      @(posedge clk_sys_i) unit_a <= 3'h1;
      unit_b <= 3'h4;
      src[5] <= 1'b0;
      tick(3);
      chk({29'h0, line_drive}, 32'h0000_0000);
      chk({31'h0, aux1}, 32'h0000_0001);
      chk({30'h0, bank}, 32'h0000_0001);
      $display("test assignment done");
      // ============================================================
      // interrupt raise, mask, clear
      axi_wr(shared_bus_pkg::ADDR_IRQ_STAT, 32'h0000_001f, ok);
      axi_wr(shared_bus_pkg::ADDR_IRQ_MASK, 32'h0000_0004, ok);
      unit_b <= 3'h0;
      tick(2);
      chk({31'h0, fchange[1]}, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0001);
      chk({30'h0, bank}, 32'h0000_0000);
      axi_wr(shared_bus_pkg::ADDR_IRQ_MASK, 32'h0000_0000, ok);
      tick(1);
      chk({31'h0, irq}, 32'h0000_0000);
      axi_wr(shared_bus_pkg::ADDR_IRQ_MASK, 32'h0000_0004, ok);
      tick(1);
      chk({31'h0, irq}, 32'h0000_0001);
      axi_wr(shared_bus_pkg::ADDR_IRQ_STAT, 32'h0000_0004, ok);
      tick(1);
      chk({31'h0, irq}, 32'h0000_0000);
      $display("test interrupt done");
      // ============================================================
      // interface events onto line one
      unit_a <= 3'h0;
      axi_wr(shared_bus_pkg::ADDR_OUT_SEL0, 32'h0000_0002, ok);
      axi_wr(shared_bus_pkg::ADDR_CTRL, 32'h0000_0002, ok);
      iface_ev <= 2'h1;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_sys_i) present <= k[0];
         multi <= k[1];
         tick(3);
         chk({31'h0, line_drive[0]}, {31'h0, k == 1});
         chk({31'h0, aux1}, {31'h0, k == 1});
      end
      $display("test interface done");
      // ============================================================
      // power-up while another unit holds line two
      @(posedge clk_sys_i) unit_b <= 3'h2;
      fault <= 16'h0001;
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      axi_rd(shared_bus_pkg::ADDR_STATUS, 32'h0000_003a, ok);
      chk({29'h0, line_drive}, 32'h0000_0000);
      axi_rd(shared_bus_pkg::ADDR_OUT_SEL0, 32'h0000_0000, ok);
      $display("test power-up done");
      end_sim();
   end
endmodule : shared_signal_bus_assign_bench

// >>> rtl/selector_store.sv
`timescale 1ns/1ps
// ============================================================
// pending and active selector words
module selector_store #(
   parameter int LINES = 3
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire shared_bus_pkg::sel_wr_t wr_i,
   input wire logic commit_i,
   input wire logic rd_is_out_i,
   input wire logic [1:0] rd_idx_i,
   output logic [7:0] rd_data_o,
   output shared_bus_pkg::line_sel_t [LINES-1:0] active_o
);
   shared_bus_pkg::line_sel_t [LINES-1:0] pending;
   shared_bus_pkg::line_sel_t [LINES-1:0] next_pending;
   shared_bus_pkg::line_sel_t [LINES-1:0] next_active;
   logic [7:0] next_rd_data;

   always_comb begin
      next_pending = pending;
      next_active = active_o;
      next_rd_data = 8'h00;
      if (wr_i.en && int'(wr_i.idx) < LINES) begin
         if (wr_i.is_out) begin
            next_pending[wr_i.idx].out_code = wr_i.code;
         end else begin
            next_pending[wr_i.idx].in_code = wr_i.code;
         end
      end
      // new codes only go live on a soft reset; power-up is rst_n_i
      if (commit_i) begin
         next_active = next_pending;
      end
      if (int'(rd_idx_i) < LINES) begin
         next_rd_data = rd_is_out_i ? pending[rd_idx_i].out_code :
            pending[rd_idx_i].in_code;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pending <= '{default: shared_bus_pkg::SEL_DEFAULT};
         active_o <= '{default: shared_bus_pkg::SEL_DEFAULT};
         rd_data_o <= 8'h00;
      end else begin
         pending <= next_pending;
         active_o <= next_active;
         rd_data_o <= next_rd_data;
      end
   end
endmodule : selector_store

// >>> rtl/shared_bus_pkg.sv
// ============================================================
// shared line assignment constants and carriers
package shared_bus_pkg;
   localparam int LINES = 3;
   localparam int CODE_W = 8;
   localparam int ADDR_W = 8;
   localparam int IN_CODES = 133;
   localparam int OUT_CODES = 151;
   // ============================================================
   // selector ranges per variant
   localparam logic [7:0] IN_MAX_FOUR = 8'h84;
   localparam logic [7:0] IN_MAX_TWO = 8'h45;
   localparam logic [7:0] OUT_MAX_FOUR = 8'h96;
   localparam logic [7:0] OUT_MAX_TWO = 8'h57;
   localparam logic [7:0] SEL_DEFAULT = 8'h00;
   // ============================================================
   // selector codes with fixed meaning
   localparam logic [7:0] CODE_NONE = 8'h00;
   localparam logic [7:0] OUT_CODE_FAULT = 8'h01;
   localparam logic [7:0] OUT_CODE_IFACE_EV1 = 8'h02;
   localparam logic [7:0] OUT_CODE_IFACE_EV2 = 8'h03;
   localparam logic [7:0] IN_CODE_BANK_BIT0 = 8'h01;
   localparam logic [7:0] IN_CODE_BANK_BIT1 = 8'h02;
   localparam int FAULT_MSB = 13;
   // ============================================================
   // register map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IN_SEL0 = 8'h08;
   localparam logic [7:0] ADDR_OUT_SEL0 = 8'h14;
   localparam logic [7:0] SEL_SPAN = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_SRST_BIT = 1;
   localparam int STAT_FAULT_BIT = 3;
   localparam int STAT_IFACE_BIT = 4;
   localparam int STAT_MULTI_BIT = 5;
   localparam int IRQ_W = 5;
   localparam int IRQ_REFUSE_BIT = 3;
   localparam int IRQ_FAULT_BIT = 4;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ============================================================
   // carriers
   typedef struct packed {
      logic en;
      logic is_out;
      logic [1:0] idx;
      logic [CODE_W-1:0] code;
   } sel_wr_t;
   typedef struct packed {
      logic [CODE_W-1:0] in_code;
      logic [CODE_W-1:0] out_code;
   } line_sel_t;
endpackage : shared_bus_pkg

// >>> rtl/shared_signal_bus_assign.sv
`timescale 1ns/1ps
// ============================================================
module shared_signal_bus_assign #(
   parameter bit FOUR_CHANNEL = 1'b1
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   output logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   input wire logic [7:0] s_axi_araddr_i,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   input wire logic [2:0] line_in_i,
   output logic [2:0] line_drive_o,
   output logic end_aux_output_one_o,
   output logic end_aux_output_two_o,
   input wire logic [15:0] fault_status_i,
   input wire logic [150:0] src_i,
   input wire logic [1:0] iface_event_i,
   input wire logic iface_present_i,
   input wire logic multidrop_i,
   output logic [132:0] func_level_o,
   output logic [132:0] func_change_o,
   output logic [1:0] bank_o,
   output logic irq_o
);
   localparam int LINES = shared_bus_pkg::LINES;
   localparam int IN_W = shared_bus_pkg::IN_CODES;
   localparam int OUT_W = shared_bus_pkg::OUT_CODES;

   // ============================================================
   // helpers
   function automatic logic code_ok(input logic [7:0] code,
                                    input logic is_out);
      logic [7:0] lim;
      if (is_out) begin
         lim = FOUR_CHANNEL ? shared_bus_pkg::OUT_MAX_FOUR :
            shared_bus_pkg::OUT_MAX_TWO;
      end else begin
         lim = FOUR_CHANNEL ? shared_bus_pkg::IN_MAX_FOUR :
            shared_bus_pkg::IN_MAX_TWO;
      end
      return code <= lim;
   endfunction : code_ok

   // returns {hit, is_out, idx}
   function automatic logic [3:0] sel_decode(input logic [7:0] a);
      logic [7:0] off;
      off = 8'h00;
      if (a[1:0] != 2'b00) begin
         return 4'h0;
      end
      if (a >= shared_bus_pkg::ADDR_IN_SEL0 &&
          a < shared_bus_pkg::ADDR_IN_SEL0 + shared_bus_pkg::SEL_SPAN) begin
         off = a - shared_bus_pkg::ADDR_IN_SEL0;
         return {2'b10, off[3:2]};
      end
      if (a >= shared_bus_pkg::ADDR_OUT_SEL0 &&
          a < shared_bus_pkg::ADDR_OUT_SEL0 + shared_bus_pkg::SEL_SPAN) begin
         off = a - shared_bus_pkg::ADDR_OUT_SEL0;
         return {2'b11, off[3:2]};
      end
      return 4'h0;
   endfunction : sel_decode

   // ============================================================
   // state
   logic aw_full, next_aw_full;
   logic [7:0] aw_addr, next_aw_addr;
   logic w_full, next_w_full;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic rd_pend, next_rd_pend;
   logic [7:0] ar_addr, next_ar_addr;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic ctrl_run, next_ctrl_run;
   logic [shared_bus_pkg::IRQ_W-1:0] irq_stat, next_irq_stat;
   logic [shared_bus_pkg::IRQ_W-1:0] irq_mask, next_irq_mask;
   logic [2:0] next_line_drive;
   logic [2:0] prev_line;
   logic primed;
   logic fault_prev;
   logic [IN_W-1:0] next_func_level;
   logic [IN_W-1:0] next_func_change;

   logic wr_go;
   logic [3:0] wdec;
   logic [3:0] rdec;
   logic commit;
   logic refuse_ev;
   logic [shared_bus_pkg::IRQ_W-1:0] w1c;
   logic [shared_bus_pkg::IRQ_W-1:0] irq_ev;
   logic fault_sig;
   logic iface_ok;
   logic [OUT_W-1:0] srcv;
   logic [2:0] line_state;
   logic [2:0] line_chg;
   logic [7:0] sel_rd;
   shared_bus_pkg::sel_wr_t sel_wr;
   shared_bus_pkg::line_sel_t [LINES-1:0] active;

   // ============================================================
   // selector storage
   selector_store #(
      .LINES(LINES)
   ) u_store (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .wr_i(sel_wr),
      .commit_i(commit),
      .rd_is_out_i(rdec[2]),
      .rd_idx_i(rdec[1:0]),
      .rd_data_o(sel_rd),
      .active_o(active)
   );

   // ============================================================
   // register write path
   assign s_axi_awready_o = !aw_full;
   assign s_axi_wready_o = !w_full;
   assign wr_go = aw_full && w_full && !s_axi_bvalid_o;
   assign wdec = sel_decode(aw_addr);

   always_comb begin
      next_aw_full = aw_full;
      next_aw_addr = aw_addr;
      next_w_full = w_full;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = s_axi_bvalid_o;
      next_bresp = s_axi_bresp_o;
      next_ctrl_run = ctrl_run;
      next_irq_mask = irq_mask;
      sel_wr = '0;
      commit = 1'b0;
      refuse_ev = 1'b0;
      w1c = '0;
      if (s_axi_awvalid_i && !aw_full) begin
         next_aw_full = 1'b1;
         next_aw_addr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_full) begin
         next_w_full = 1'b1;
         next_w_data = s_axi_wdata_i;
         next_w_strb = s_axi_wstrb_i;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
         next_bvalid = 1'b0;
      end
      if (wr_go) begin
         next_aw_full = 1'b0;
         next_w_full = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = shared_bus_pkg::RESP_OKAY;
         if (wdec[3]) begin
            if (ctrl_run || !code_ok(w_data[7:0], wdec[2])) begin
               next_bresp = shared_bus_pkg::RESP_SLVERR;
               refuse_ev = 1'b1;
            end else if (w_strb[0]) begin
               sel_wr.en = 1'b1;
               sel_wr.is_out = wdec[2];
               sel_wr.idx = wdec[1:0];
               sel_wr.code = w_data[7:0];
            end
         end else if (aw_addr == shared_bus_pkg::ADDR_CTRL) begin
            if (w_strb[0]) begin
               next_ctrl_run = w_data[shared_bus_pkg::CTRL_RUN_BIT];
               commit = w_data[shared_bus_pkg::CTRL_SRST_BIT];
            end
         end else if (aw_addr == shared_bus_pkg::ADDR_IRQ_STAT) begin
            if (w_strb[0]) begin
               w1c = w_data[shared_bus_pkg::IRQ_W-1:0];
            end
         end else if (aw_addr == shared_bus_pkg::ADDR_IRQ_MASK) begin
            if (w_strb[0]) begin
               next_irq_mask = w_data[shared_bus_pkg::IRQ_W-1:0];
            end
         end else if (aw_addr != shared_bus_pkg::ADDR_STATUS) begin
            next_bresp = shared_bus_pkg::RESP_SLVERR;
         end
      end
   end

   // ============================================================
   // register read path
   assign s_axi_arready_o = !rd_pend && !s_axi_rvalid_o;
   // the selector store samples this every cycle; its word is
   // only used one cycle after the address was taken
   assign rdec = sel_decode(s_axi_araddr_i);

   always_comb begin
      next_rd_pend = rd_pend;
      next_ar_addr = ar_addr;
      next_rvalid = s_axi_rvalid_o;
      next_rdata = s_axi_rdata_o;
      next_rresp = s_axi_rresp_o;
      if (s_axi_rvalid_o && s_axi_rready_i) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && s_axi_arready_o) begin
         next_rd_pend = 1'b1;
         next_ar_addr = s_axi_araddr_i;
      end
      if (rd_pend) begin
         next_rd_pend = 1'b0;
         next_rvalid = 1'b1;
         next_rdata = 32'h0000_0000;
         next_rresp = shared_bus_pkg::RESP_OKAY;
         if (sel_decode(ar_addr) != 4'h0) begin
            next_rdata[7:0] = sel_rd;
         end else if (ar_addr == shared_bus_pkg::ADDR_CTRL) begin
            next_rdata[shared_bus_pkg::CTRL_RUN_BIT] = ctrl_run;
         end else if (ar_addr == shared_bus_pkg::ADDR_STATUS) begin
            next_rdata[2:0] = line_state;
            next_rdata[shared_bus_pkg::STAT_FAULT_BIT] = fault_sig;
            next_rdata[shared_bus_pkg::STAT_IFACE_BIT] = iface_present_i;
            next_rdata[shared_bus_pkg::STAT_MULTI_BIT] = multidrop_i;
         end else if (ar_addr == shared_bus_pkg::ADDR_IRQ_STAT) begin
            next_rdata[shared_bus_pkg::IRQ_W-1:0] = irq_stat;
         end else if (ar_addr == shared_bus_pkg::ADDR_IRQ_MASK) begin
            next_rdata[shared_bus_pkg::IRQ_W-1:0] = irq_mask;
         end else begin
            next_rresp = shared_bus_pkg::RESP_SLVERR;
         end
      end
   end

   // ============================================================
   // line drive and sampling
   assign fault_sig = |fault_status_i[shared_bus_pkg::FAULT_MSB:0];
   assign iface_ok = iface_present_i && !multidrop_i;
   // own drive is folded in so this unit sees its own output
   assign line_state = line_in_i | line_drive_o;
   assign line_chg = primed ? (line_state ^ prev_line) : 3'b000;

   always_comb begin
      srcv = src_i;
      srcv[shared_bus_pkg::CODE_NONE] = 1'b0;
      srcv[shared_bus_pkg::OUT_CODE_FAULT] = fault_sig;
      srcv[shared_bus_pkg::OUT_CODE_IFACE_EV1] =
         iface_event_i[0] && iface_ok;
      srcv[shared_bus_pkg::OUT_CODE_IFACE_EV2] = iface_event_i[1] && iface_ok;
      for (int l = 0; l < LINES; l++) begin
         next_line_drive[l] = 1'b0;
         if (int'(active[l].out_code) < OUT_W) begin
            next_line_drive[l] = srcv[active[l].out_code];
         end
      end
   end

   always_comb begin
      next_func_level = '0;
      next_func_change = '0;
      for (int l = 0; l < LINES; l++) begin
         if (active[l].in_code != shared_bus_pkg::CODE_NONE &&
             int'(active[l].in_code) < IN_W) begin
            // levels act from the first cycle, edges once primed
            next_func_level[active[l].in_code] =
               next_func_level[active[l].in_code] | line_state[l];
            next_func_change[active[l].in_code] =
               next_func_change[active[l].in_code] | line_chg[l];
         end
      end
   end

   // ============================================================
   // interrupts
   always_comb begin
      irq_ev = '0;
      irq_ev[2:0] = line_chg;
      irq_ev[shared_bus_pkg::IRQ_REFUSE_BIT] = refuse_ev;
      irq_ev[shared_bus_pkg::IRQ_FAULT_BIT] = fault_sig && !fault_prev;
      // a new event wins over a clear in the same cycle
      next_irq_stat = (irq_stat & ~w1c) | irq_ev;
   end

   assign irq_o = |(irq_stat & irq_mask);

   // ============================================================
   // registers
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_full <= 1'b0;
         aw_addr <= 8'h00;
         w_full <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= shared_bus_pkg::RESP_OKAY;
         rd_pend <= 1'b0;
         ar_addr <= 8'h00;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0000_0000;
         s_axi_rresp_o <= shared_bus_pkg::RESP_OKAY;
         ctrl_run <= 1'b0;
         irq_stat <= shared_bus_pkg::IRQ_RESET;
         irq_mask <= shared_bus_pkg::IRQ_RESET;
         line_drive_o <= 3'b000;
         prev_line <= 3'b000;
         primed <= 1'b0;
         fault_prev <= 1'b0;
         end_aux_output_one_o <= 1'b0;
         end_aux_output_two_o <= 1'b0;
         func_level_o <= '0;
         func_change_o <= '0;
         bank_o <= 2'b00;
      end else begin
         aw_full <= next_aw_full;
         aw_addr <= next_aw_addr;
         w_full <= next_w_full;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_bvalid_o <= next_bvalid;
         s_axi_bresp_o <= next_bresp;
         rd_pend <= next_rd_pend;
         ar_addr <= next_ar_addr;
         s_axi_rvalid_o <= next_rvalid;
         s_axi_rdata_o <= next_rdata;
         s_axi_rresp_o <= next_rresp;
         ctrl_run <= next_ctrl_run;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         line_drive_o <= next_line_drive;
         prev_line <= line_state;
         primed <= 1'b1;
         fault_prev <= fault_sig;
         end_aux_output_one_o <= line_state[0];
         end_aux_output_two_o <= line_state[1];
         func_level_o <= next_func_level;
         func_change_o <= next_func_change;
         // every unit sampling the same line flips its bank together
         bank_o <= {next_func_level[shared_bus_pkg::IN_CODE_BANK_BIT1],
            next_func_level[shared_bus_pkg::IN_CODE_BANK_BIT0]};
      end
   end
endmodule : shared_signal_bus_assign
